//--- logic/sib_pkg.sv
`default_nettype none
package sib_pkg;
  // host side timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          SCL_PERIOD_NS = 2500;
  localparam int          QTR_CYC       =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  QTR_LAST      = 5'(QTR_CYC - 1);
  // device register map
  localparam logic [7:0]  OE_REG_IDX    = 8'h00;
  localparam logic [7:0]  OE_RESET      = 8'hEE;
  localparam logic [7:0]  OE_WR_MASK    = 8'h6A;
  localparam int          PAIR_BIT [4]  = '{1, 3, 5, 6};
  localparam logic [7:0]  COUNT_RESET   = 8'h08;
  // latched slave address per select level; values are arbitrary
  localparam logic [1:0]  ADSEL_LOW     = 2'h0;
  localparam logic [1:0]  ADSEL_MID     = 2'h1;
  localparam logic [6:0]  SLAVE_LOW     = 7'h50;
  localparam logic [6:0]  SLAVE_MID     = 7'h51;
  localparam logic [6:0]  SLAVE_HIGH    = 7'h52;
  // host controller register map
  localparam logic [3:0]  HREG_CTRL     = 4'h0;
  localparam logic [3:0]  HREG_STATUS   = 4'h1;
  localparam logic [3:0]  HREG_SLAVE    = 4'h2;
  localparam logic [3:0]  HREG_INDEX    = 4'h3;
  localparam logic [3:0]  HREG_COUNT    = 4'h4;
  localparam logic [3:0]  HREG_RXCOUNT  = 4'h5;
  localparam int          HREG_BUF_BIT  = 3;
  localparam int          CTRL_GO_BIT   = 0;
  localparam int          CTRL_READ_BIT = 1;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_NACK_BIT = 1;
  localparam int          HBUF_DEPTH    = 8;
  localparam logic [6:0]  HSLAVE_RESET  = 7'h50;
  localparam logic [3:0]  HCOUNT_RESET  = 4'h1;
endpackage
`default_nettype wire

//--- logic/sib_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sib_link_if;
  logic scl;
  logic sda;
  logic host_scl_oe_n;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;

  // pulled-up lines: low whenever any party enables its driver
  assign scl = host_scl_oe_n;
  assign sda = host_sda_oe_n & dev_sda_oe_n;

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_oe_n
  );
  modport host (
    input  sda,
    output host_scl_oe_n,
    output host_sda_oe_n
  );
endinterface
`default_nettype wire

//--- logic/sib_dev.sv
// Overview of operation
// - host opens write: start, address, write bit
// - index byte N sent and acknowledged
// - byte count follows index, acknowledged
// - data stored N onward, each byte acknowledged
// - host ends write with stop
// - read: index, repeated start, address read
// - device sends byte count first
// - then registers from N upward
// - host acknowledges all but final byte
// - host nacks final byte, stops; device releases
// - slave address from latched select pin
// - bits 6,5,3,1 gate pairs 3,2,1,0
// - enable bits read/write, default one
// - cleared bit overrides active-low enable pin
// - interface lives only on input clock
`timescale 1ns/1ps
`default_nettype none
module sib_dev (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  sib_link_if.dev         link,
  input  wire logic [1:0] addr_select_pin_i,
  input  wire logic [3:0] pair_oe_n_i,
  output logic      [3:0] diff_clock_output_en_o
);
  import sib_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE,
    D_RX,
    D_ACK,
    D_TX,
    D_TXACK
  } sib_dstate_type;

  typedef enum logic [1:0] {
    R_ADDR,
    R_INDEX,
    R_COUNT,
    R_DATA
  } sib_role_type;

  logic           rst_s1_ff;
  logic           rst_ff;
  logic           scl_s1_ff;
  logic           scl_s2_ff;
  logic           scl_q_ff;
  logic           sda_s1_ff;
  logic           sda_s2_ff;
  logic           sda_q_ff;
  logic [1:0]     adsel_s1_ff;
  logic [1:0]     adsel_s2_ff;
  logic [3:0]     oe_pin_s1_ff;
  logic [3:0]     oe_pin_s2_ff;
  logic           addr_taken_ff;
  logic [6:0]     addr_ff;
  sib_dstate_type state_ff;
  sib_role_type   role_ff;
  logic [3:0]     bit_ff;
  logic [7:0]     sh_ff;
  logic           read_ff;
  logic [7:0]     index_ff;
  logic [7:0]     count_ff;
  logic [7:0]     oe_reg_ff;
  logic           sda_oe_n_ff;
  logic [3:0]     pair_en_ff;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_seen;
  logic           stop_seen;
  logic [7:0]     rd_byte;

  //////////////////////////////////////////////////////////////////////////////
  // crossings: whole device runs on the input clock, so with it stopped
  // nothing answers on the bus
  always_ff @(posedge ref_clk_i) begin
    rst_s1_ff    <= reset_i;
    rst_ff       <= rst_s1_ff;
    scl_s1_ff    <= link.scl;
    scl_s2_ff    <= scl_s1_ff;
    scl_q_ff     <= scl_s2_ff;
    sda_s1_ff    <= link.sda;
    sda_s2_ff    <= sda_s1_ff;
    sda_q_ff     <= sda_s2_ff;
    adsel_s1_ff  <= addr_select_pin_i;
    adsel_s2_ff  <= adsel_s1_ff;
    oe_pin_s1_ff <= pair_oe_n_i;
    oe_pin_s2_ff <= oe_pin_s1_ff;
  end

  assign scl_rise   = scl_s2_ff & ~scl_q_ff;
  assign scl_fall   = ~scl_s2_ff & scl_q_ff;
  assign start_seen = scl_s2_ff & scl_q_ff & sda_q_ff & ~sda_s2_ff;
  assign stop_seen  = scl_s2_ff & scl_q_ff & ~sda_q_ff & sda_s2_ff;

  //////////////////////////////////////////////////////////////////////////////
  // address caught once after reset; later pin moves are ignored
  always_ff @(posedge ref_clk_i) begin
    if (rst_ff) begin
      addr_taken_ff <= 1'b0;
      addr_ff       <= 7'h00;
    end else if (!addr_taken_ff) begin
      addr_taken_ff <= 1'b1;
      unique case (adsel_s2_ff)
        ADSEL_LOW: begin
          addr_ff <= SLAVE_LOW;
        end
        ADSEL_MID: begin
          addr_ff <= SLAVE_MID;
        end
        default: begin
          addr_ff <= SLAVE_HIGH;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indices other than the enable register read as zero
  assign rd_byte = (index_ff == OE_REG_IDX) ? oe_reg_ff : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (rst_ff) begin
      state_ff    <= D_IDLE;
      role_ff     <= R_ADDR;
      bit_ff      <= 4'h0;
      sh_ff       <= 8'h00;
      read_ff     <= 1'b0;
      index_ff    <= 8'h00;
      count_ff    <= COUNT_RESET;
      oe_reg_ff   <= OE_RESET;
      sda_oe_n_ff <= 1'b1;
    end else if (start_seen && addr_taken_ff) begin
      // repeated start lands here too, back to address phase
      state_ff    <= D_RX;
      role_ff     <= R_ADDR;
      bit_ff      <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else if (stop_seen) begin
      state_ff    <= D_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        D_IDLE: begin
          sda_oe_n_ff <= 1'b1;
        end
        D_RX: begin
          if (scl_rise) begin
            sh_ff  <= {sh_ff[6:0], sda_s2_ff};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            state_ff    <= D_ACK;
            sda_oe_n_ff <= 1'b0;
            unique case (role_ff)
              R_ADDR: begin
                if (sh_ff[7:1] != addr_ff) begin
                  state_ff    <= D_IDLE;
                  sda_oe_n_ff <= 1'b1;
                end else begin
                  read_ff <= sh_ff[0];
                  role_ff <= R_INDEX;
                end
              end
              R_INDEX: begin
                index_ff <= sh_ff;
                role_ff  <= R_COUNT;
              end
              R_COUNT: begin
                count_ff <= sh_ff;
                role_ff  <= R_DATA;
              end
              R_DATA: begin
                if (index_ff == OE_REG_IDX) begin
                  // reserved bits keep their fixed values
                  oe_reg_ff <= (oe_reg_ff & ~OE_WR_MASK) |
                               (sh_ff & OE_WR_MASK);
                end
                index_ff <= index_ff + 8'h01;
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            bit_ff <= 4'h0;
            if (read_ff) begin
              state_ff    <= D_TX;
              sh_ff       <= count_ff;
              sda_oe_n_ff <= count_ff[7];
            end else begin
              state_ff    <= D_RX;
              sda_oe_n_ff <= 1'b1;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (bit_ff == 4'h7) begin
              state_ff    <= D_TXACK;
              sda_oe_n_ff <= 1'b1;
            end else begin
              bit_ff      <= bit_ff + 4'h1;
              sh_ff       <= {sh_ff[6:0], 1'b0};
              sda_oe_n_ff <= sh_ff[6];
            end
          end
        end
        D_TXACK: begin
          if (scl_rise && sda_s2_ff) begin
            // final byte refused by host: let go of the line
            state_ff <= D_IDLE;
          end else if (scl_fall) begin
            state_ff    <= D_TX;
            bit_ff      <= 4'h0;
            sh_ff       <= rd_byte;
            sda_oe_n_ff <= rd_byte[7];
            index_ff    <= index_ff + 8'h01;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // a cleared bit forces the pair off whatever the pin says
  always_ff @(posedge ref_clk_i) begin
    if (rst_ff) begin
      pair_en_ff <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        pair_en_ff[k] <= oe_reg_ff[PAIR_BIT[k]] & ~oe_pin_s2_ff[k];
      end
    end
  end

  assign link.dev_sda_oe_n      = sda_oe_n_ff;
  assign diff_clock_output_en_o = pair_en_ff;
endmodule
`default_nettype wire

//--- logic/sib_host.sv
`timescale 1ns/1ps
`default_nettype none
module sib_host (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  sib_link_if.host        link,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o
);
  import sib_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE,
    H_START,
    H_ADDR,
    H_INDEX,
    H_COUNT,
    H_WDATA,
    H_RSTART,
    H_RADDR,
    H_RCOUNT,
    H_RDATA,
    H_STOP
  } sib_hstate_type;

  sib_hstate_type stage_ff;
  logic [7:0]     buf_ff [HBUF_DEPTH];
  logic [6:0]     slave_ff;
  logic [7:0]     index_ff;
  logic [3:0]     count_ff;
  logic [7:0]     rxcount_ff;
  logic           read_op_ff;
  logic           nack_ff;
  logic [7:0]     rdata_ff;
  logic           sda_s1_ff;
  logic           sda_s2_ff;
  logic [4:0]     tick_cnt_ff;
  logic [1:0]     phase_ff;
  logic [3:0]     bit_ff;
  logic [7:0]     sh_ff;
  logic [2:0]     idx_ff;
  logic           scl_oe_n_ff;
  logic           sda_oe_n_ff;
  logic           busy;
  logic           go;
  logic           tick;
  logic           rx_stage;
  logic           last_byte;
  logic           buf_wr;

  assign busy      = (stage_ff != H_IDLE);
  assign go        = wr_i && addr_i == HREG_CTRL && wdata_i[CTRL_GO_BIT] && !busy;
  assign tick      = busy && tick_cnt_ff == QTR_LAST;
  assign rx_stage  = (stage_ff == H_RCOUNT) || (stage_ff == H_RDATA);
  assign last_byte = ({1'b0, idx_ff} == count_ff - 4'h1);
  assign buf_wr    = wr_i && addr_i[HREG_BUF_BIT];

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    sda_s1_ff <= link.sda;
    sda_s2_ff <= sda_s1_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      slave_ff   <= HSLAVE_RESET;
      index_ff   <= 8'h00;
      count_ff   <= HCOUNT_RESET;
      read_op_ff <= 1'b0;
    end else if (wr_i && !busy) begin
      unique case (addr_i)
        HREG_CTRL:  read_op_ff <= wdata_i[CTRL_READ_BIT];
        HREG_SLAVE: slave_ff   <= wdata_i[6:0];
        HREG_INDEX: index_ff   <= wdata_i;
        HREG_COUNT: count_ff   <= wdata_i[3:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      if (addr_i[HREG_BUF_BIT]) begin
        rdata_ff <= buf_ff[addr_i[2:0]];
      end else begin
        unique case (addr_i)
          HREG_STATUS:  rdata_ff <= {6'h00, nack_ff, busy};
          HREG_SLAVE:   rdata_ff <= {1'b0, slave_ff};
          HREG_INDEX:   rdata_ff <= index_ff;
          HREG_COUNT:   rdata_ff <= {4'h0, count_ff};
          HREG_RXCOUNT: rdata_ff <= rxcount_ff;
          default:      rdata_ff <= 8'h00;
        endcase
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !busy || tick) begin
      tick_cnt_ff <= 5'h00;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit engine: quarter 0 sets data, 1 raises clock, 2 samples, 3 lowers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stage_ff    <= H_IDLE;
      phase_ff    <= 2'h0;
      bit_ff      <= 4'h0;
      sh_ff       <= 8'h00;
      idx_ff      <= 3'h0;
      nack_ff     <= 1'b0;
      rxcount_ff  <= 8'h00;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      for (int i = 0; i < HBUF_DEPTH; i++) begin
        buf_ff[i] <= 8'h00;
      end
    end else if (go) begin
      stage_ff <= H_START;
      phase_ff <= 2'h0;
      nack_ff  <= 1'b0;
    end else if (buf_wr && !busy) begin
      buf_ff[addr_i[2:0]] <= wdata_i;
    end else if (tick) begin
      phase_ff <= phase_ff + 2'h1;
      unique case (stage_ff)
        H_START, H_RSTART: begin
          unique case (phase_ff)
            2'h0: begin
              // scl left alone: no stray clock pulse on an idle bus
              sda_oe_n_ff <= 1'b1;
            end
            2'h1: scl_oe_n_ff <= 1'b1;
            2'h2: sda_oe_n_ff <= 1'b0;
            2'h3: begin
              scl_oe_n_ff <= 1'b0;
              bit_ff      <= 4'h0;
              sh_ff       <= {slave_ff, stage_ff == H_RSTART};
              stage_ff    <= (stage_ff == H_START) ? H_ADDR : H_RADDR;
            end
          endcase
        end
        H_STOP: begin
          unique case (phase_ff)
            2'h0: begin
              scl_oe_n_ff <= 1'b0;
              sda_oe_n_ff <= 1'b0;
            end
            2'h1: scl_oe_n_ff <= 1'b1;
            2'h2: sda_oe_n_ff <= 1'b1;
            2'h3: stage_ff <= H_IDLE;
          endcase
        end
        H_IDLE: ;
        default: begin
          unique case (phase_ff)
            2'h0: begin
              scl_oe_n_ff <= 1'b0;
              if (bit_ff != 4'h8) begin
                sda_oe_n_ff <= rx_stage ? 1'b1 : sh_ff[7];
              end else begin
                // acknowledge all but the final read byte
                // write slots stay released so the device can answer
                sda_oe_n_ff <= !rx_stage ||
                               (stage_ff == H_RDATA && last_byte);
              end
            end
            2'h1: scl_oe_n_ff <= 1'b1;
            2'h2: begin
              if (bit_ff != 4'h8 && rx_stage) begin
                sh_ff <= {sh_ff[6:0], sda_s2_ff};
              end else if (bit_ff == 4'h8 && !rx_stage && sda_s2_ff) begin
                nack_ff <= 1'b1;
              end
            end
            2'h3: begin
              scl_oe_n_ff <= 1'b0;
              if (bit_ff != 4'h8) begin
                bit_ff <= bit_ff + 4'h1;
                if (!rx_stage) begin
                  sh_ff <= {sh_ff[6:0], 1'b0};
                end
              end else if (!rx_stage && nack_ff) begin
                // refused byte: lower the clock first, then stop
                bit_ff   <= 4'h0;
                stage_ff <= H_STOP;
              end else begin
                bit_ff <= 4'h0;
                unique case (stage_ff)
                  H_ADDR: begin
                    stage_ff <= H_INDEX;
                    sh_ff    <= index_ff;
                  end
                  H_INDEX: begin
                    stage_ff <= read_op_ff ? H_RSTART : H_COUNT;
                    sh_ff    <= {4'h0, count_ff};
                  end
                  H_COUNT: begin
                    stage_ff <= (count_ff == 4'h0) ? H_STOP : H_WDATA;
                    idx_ff   <= 3'h0;
                    sh_ff    <= buf_ff[0];
                  end
                  H_WDATA: begin
                    stage_ff <= last_byte ? H_STOP : H_WDATA;
                    idx_ff   <= idx_ff + 3'h1;
                    sh_ff    <= buf_ff[3'(idx_ff + 3'h1)];
                  end
                  H_RADDR: begin
                    stage_ff <= H_RCOUNT;
                  end
                  H_RCOUNT: begin
                    rxcount_ff <= sh_ff;
                    idx_ff     <= 3'h0;
                    stage_ff   <= H_RDATA;
                  end
                  H_RDATA: begin
                    buf_ff[idx_ff] <= sh_ff;
                    idx_ff         <= idx_ff + 3'h1;
                    stage_ff       <= last_byte ? H_STOP : H_RDATA;
                  end
                  default: stage_ff <= H_STOP;
                endcase
              end
            end
          endcase
        end
      endcase
    end
  end

  assign link.host_scl_oe_n = scl_oe_n_ff;
  assign link.host_sda_oe_n = sda_oe_n_ff;
  assign rdata_o            = rdata_ff;
endmodule
`default_nettype wire

//--- sim/sib_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sib_checker (
  input  wire logic mclk_i,
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic host_scl_oe_n,
  input  wire logic host_sda_oe_n,
  input  wire logic dev_sda_oe_n
);
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic [3:0] bit_ff;
  logic [3:0] byte_ff;
  logic       rw_ff;
  logic       done_ff;
  logic [9:0] low_ff;
  logic       start;
  logic       rise;
  logic       slot;
  assign start = scl & scl_q_ff & sda_q_ff & ~sda;
  assign rise  = scl & ~scl_q_ff;
  assign slot  = rise & (bit_ff == 4'h8);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    scl_q_ff <= reset_i | scl;
    sda_q_ff <= reset_i | sda;
  end
  // bit and byte position since the last start or repeated start
  always_ff @(posedge mclk_i) begin
    if (reset_i || start) begin
      bit_ff  <= 4'h0;
      byte_ff <= 4'h0;
    end else if (slot) begin
      bit_ff  <= 4'h0;
      byte_ff <= (byte_ff == 4'hF) ? byte_ff : byte_ff + 4'h1;
    end else if (rise) begin
      bit_ff <= bit_ff + 4'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rw_ff <= 1'b0;
    end else if (rise && bit_ff == 4'h7 && byte_ff == 4'h0) begin
      rw_ff <= sda;
    end
  end
  // refused byte seen: only the stop clock may follow
  always_ff @(posedge mclk_i) begin
    if (reset_i || start) begin
      done_ff <= 1'b0;
    end else if (slot && sda) begin
      done_ff <= 1'b1;
    end
  end
  // saturating: a zero byte plus its ack stays just below the cap
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || dev_sda_oe_n) begin
      low_ff <= 10'h000;
    end else if (low_ff != 10'h190) begin
      low_ff <= low_ff + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_idx_ack;
    @(posedge mclk_i) disable iff (reset_i)
    slot && byte_ff == 4'h1 && !rw_ff |-> !dev_sda_oe_n;
  endproperty
  a_idx_ack: assert property (p_idx_ack) else $error("index not acked");
  property p_cnt_ack;
    @(posedge mclk_i) disable iff (reset_i)
    slot && byte_ff == 4'h2 && !rw_ff |-> !dev_sda_oe_n;
  endproperty
  a_cnt_ack: assert property (p_cnt_ack) else $error("count not acked");
  property p_data_ack;
    @(posedge mclk_i) disable iff (reset_i)
    slot && byte_ff > 4'h2 && !rw_ff |-> !dev_sda_oe_n;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data not acked");
  property p_addr_quiet;
    @(posedge mclk_i) disable iff (reset_i)
    rise && byte_ff == 4'h0 && bit_ff < 4'h8 |-> dev_sda_oe_n;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("addr drive");
  property p_rx_quiet;
    @(posedge mclk_i) disable iff (reset_i)
    rise && byte_ff != 4'h0 && !rw_ff && bit_ff < 4'h8 |-> dev_sda_oe_n;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("write drive");
  property p_tx_host_off;
    @(posedge mclk_i) disable iff (reset_i)
    rise && byte_ff != 4'h0 && rw_ff && bit_ff < 4'h8 && !done_ff
      |-> host_sda_oe_n;
  endproperty
  a_tx_host_off: assert property (p_tx_host_off) else $error("host drive");
  property p_scl_high;
    @(posedge mclk_i) disable iff (reset_i)
    $rose(host_scl_oe_n) |=> host_scl_oe_n [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("short high");
  property p_drive_low;
    @(posedge ref_clk_i) disable iff (reset_i)
    $fell(dev_sda_oe_n) |-> !scl;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive scl high");
  property p_release;
    @(posedge ref_clk_i) disable iff (reset_i)
    low_ff != 10'h190;
  endproperty
  a_release: assert property (p_release) else $error("sda held");
  c_wr_data: cover property (@(posedge mclk_i) slot && byte_ff == 4'h4);
  c_rd_byte: cover property (@(posedge mclk_i) slot && rw_ff && byte_ff > 4'h2);
  c_restart: cover property (@(posedge mclk_i) start && byte_ff == 4'h2);
endmodule
`default_nettype wire

//--- sim/smbus_index_block_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_index_block_regs_tb;
  import sib_pkg::*;
  logic       mclk = 1'b0;
  logic       ref_clk = 1'b0;
  logic       ref_run = 1'b1;
  logic       reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [1:0] sel = 2'h0;
  logic [3:0] pin_n = 4'h0;
  logic [3:0] en;
  int         error_cnt = 0;
  int         num_checks = 0;
  sib_link_if sib_link_if_i ();
  sib_dev sib_dev_i (
    .ref_clk_i(ref_clk), .reset_i(reset), .link(sib_link_if_i),
    .addr_select_pin_i(sel), .pair_oe_n_i(pin_n),
    .diff_clock_output_en_o(en));
  sib_host sib_host_i (
    .mclk_i(mclk), .reset_i(reset), .link(sib_link_if_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  sib_checker sib_checker_i (
    .mclk_i(mclk), .ref_clk_i(ref_clk), .reset_i(reset),
    .scl(sib_link_if_i.scl), .sda(sib_link_if_i.sda),
    .host_scl_oe_n(sib_link_if_i.host_scl_oe_n),
    .host_sda_oe_n(sib_link_if_i.host_sda_oe_n),
    .dev_sda_oe_n(sib_link_if_i.dev_sda_oe_n));
  always #25 mclk = ~mclk;
  // gated so the device can be starved of its input clock
  always #32 if (ref_run) ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_reg(input string nm, input logic [3:0] a,
                         input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, e, d);
  endtask
  task automatic xfer(input logic dir, input logic [3:0] cnt);
    logic [7:0] s;
    int         n;
    wr_reg(HREG_INDEX, OE_REG_IDX);
    wr_reg(HREG_COUNT, {4'h0, cnt});
    wr_reg(HREG_CTRL, {6'h00, dir, 1'b1});
    n = 0;
    s = 8'h01;
    while (s[STAT_BUSY_BIT] !== 1'b0 && n < 4000) begin
      rd_reg(HREG_STATUS, s);
      n++;
    end
    chk("busy", 8'h00, {7'h00, s[STAT_BUSY_BIT]});
  endtask
  task automatic wr_oe(input logic [7:0] d);
    wr_reg(4'h8, d);
    xfer(1'b0, 4'h1);
  endtask
  function automatic logic [7:0] oe_exp(input logic [7:0] d);
    return (OE_RESET & ~OE_WR_MASK) | (d & OE_WR_MASK);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (20) @(posedge mclk);
    // address was latched at low level; later pin moves must not matter
    sel <= 2'h1;
    chk("en", 8'h0F, {4'h0, en});
    xfer(1'b1, 4'h1);
    chk_reg("rxcount", HREG_RXCOUNT, COUNT_RESET);
    chk_reg("reg0", 4'h8, OE_RESET);
    wr_oe(8'h95);
    chk("en", 8'h00, {4'h0, en});
    xfer(1'b1, 4'h1);
    chk_reg("rxcount", HREG_RXCOUNT, 8'h01);
    chk_reg("reg0", 4'h8, oe_exp(8'h95));
    for (int k = 0; k < 4; k++) begin
      wr_oe(8'h01 << PAIR_BIT[k]);
      chk("en", 8'h01 << k, {4'h0, en});
    end
    wr_reg(4'h8, 8'h6A);
    wr_reg(4'h9, 8'h11);
    wr_reg(4'hA, 8'h22);
    xfer(1'b0, 4'h3);
    chk_reg("count", HREG_COUNT, 8'h03);
    chk_reg("index", HREG_INDEX, OE_REG_IDX);
    xfer(1'b1, 4'h3);
    chk_reg("rxcount", HREG_RXCOUNT, 8'h03);
    chk_reg("buf0", 4'h8, oe_exp(8'h6A));
    chk_reg("buf1", 4'h9, 8'h00);
    chk_reg("buf2", 4'hA, 8'h00);
    pin_n <= 4'h5;
    repeat (10) @(posedge mclk);
    chk("en", 8'h0A, {4'h0, en});
    pin_n <= 4'h0;
    wr_reg(HREG_SLAVE, {1'b0, SLAVE_MID});
    chk_reg("slave", HREG_SLAVE, {1'b0, SLAVE_MID});
    wr_oe(8'h00);
    chk_reg("status", HREG_STATUS, 8'h02);
    chk("en", 8'h0F, {4'h0, en});
    wr_reg(HREG_SLAVE, {1'b0, SLAVE_LOW});
    wr_oe(8'h00);
    chk_reg("status", HREG_STATUS, 8'h00);
    chk("en", 8'h00, {4'h0, en});
    ref_run <= 1'b0;
    wr_oe(8'h6A);
    chk_reg("status", HREG_STATUS, 8'h02);
    chk("en", 8'h00, {4'h0, en});
    conclude;
  end
endmodule
`default_nettype wire
